// ### verilog/msp_defines.vh
// Constants for the statistics counters and PHY management block.
// Assumes a 32-bit Wishbone slave, word-aligned registers, data in bits 15:0.
`ifndef MSP_DEFINES_VH
`define MSP_DEFINES_VH

// Word index of each register, byte address is index times four
`define MSP_IDX_CTRL 4'h0
`define MSP_IDX_OVF_ATT 4'h1
`define MSP_IDX_DEFER 4'h2
`define MSP_IDX_RX_MCAST 4'h3
`define MSP_IDX_RX_BCAST 4'h4
`define MSP_IDX_RX_UCAST 4'h5
`define MSP_IDX_TXB_LO 4'h6
`define MSP_IDX_TXB_HI 4'h7
`define MSP_IDX_TX_MCAST 4'h8
`define MSP_IDX_TX_BCAST 4'h9
`define MSP_IDX_TX_UCAST 4'ha
`define MSP_IDX_MGMT_CMD 4'hb
`define MSP_IDX_MGMT_DATA 4'hc
// Index of 16-bit counter k sits at bits 4k+3:4k
`define MSP_CNT16_IDX 28'ha98_5432

// Control register fields
`define MSP_CTRL_MODE16_BIT 0

// Management command/status fields
`define MSP_CMD_PHY_LSB 0
`define MSP_CMD_DIV_LSB 5
`define MSP_CMD_REG_LSB 8
`define MSP_CMD_OP_RD_BIT 13
`define MSP_CMD_IE_BIT 14
`define MSP_CMD_DONE_BIT 15
`define MSP_DIV_RESET 3'h7

// Counter limits and presets
`define MSP_SAT8 8'hff
`define MSP_SAT16 16'hffff
`define MSP_PRESET8 8'h01
`define MSP_PRESET16 16'h0001

// Management frame layout in bits
`define MSP_MF_PREAMBLE 32'hffff_ffff
`define MSP_MF_START 2'b01
`define MSP_MF_OP_RD 2'b10
`define MSP_MF_OP_WR 2'b01
`define MSP_MF_TA_WR 2'b10
`define MSP_MF_BITS 7'h40
`define MSP_MF_TA_FIRST 7'h2e
`define MSP_MF_DATA_SAMPLE 7'h31

`endif

// ### verilog/msp_stats_mgmt.v
// Statistics counters and PHY management command block of a 10/100 MAC.
// Assumes a classic Wishbone master, MAC event pulses one clock wide,
// and an external resolver for the management data pin.
//
// Notes on behaviour
// R1: Overflow count 8-bit, holds at FF.
// R2: Read of overflow count clears, 01 if missed.
// R3: Overflow and attempt registers share one word.
// R4: Attempt count captured at each attempt end.
// R5: Host reads attempts after success interrupt.
// R6: Deferral count 16-bit, saturates FFFF.
// R7: Byte mode: high byte freezes, low completes.
// R8: Word read of deferral clears or presets 0001.
// R9: Count good received multicast frames, saturate.
// R10: Count good received broadcast frames, saturate.
// R11: Count good received unicast frames, saturate.
// R12: Errored receive frames never counted.
// R13: Add sent bytes to 32-bit wrapping total.
// R14: Byte total clears, or loads last packet.
// R15: Low word read clears or preloads total.
// R16: Count sent multicast frames, saturate FFFF.
// R17: Count sent broadcast frames, saturate limit.
// R18: Count sent unicast frames, saturate FFFF.
// R19: Frame counters clear or preset 0001 on read.
// R20: Command write starts a PHY access.
// R21: Completion bit and completion interrupt enable.
// R22: MDC period is clock times 2(M+1).
// R23: Divider field resets to 111.
// R24: Data register shifted out or captured.
// R25: Single lane read leaves partner untouched.
// R26: Standard management frame format on the wire.
// R27: Freeze ends only on completing read.
`timescale 1ns/1ps
`include "msp_defines.vh"

module msp_stats_mgmt #(
  parameter BYTE_CNT_W = 16,
  parameter [15:0] TX_BCAST_SAT = 16'hffff
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rx_fifo_overflow_i,
  input wire tx_attempt_done_i,
  input wire [7:0] tx_attempt_count_i,
  input wire tx_defer_i,
  input wire rx_frame_end_i,
  input wire rx_frame_good_i,
  input wire rx_dest_mcast_i,
  input wire rx_dest_bcast_i,
  input wire tx_frame_end_i,
  input wire tx_retry_indicator_i,
  input wire tx_dest_mcast_i,
  input wire tx_dest_bcast_i,
  input wire [BYTE_CNT_W-1:0] tx_byte_count_i,
  output reg mdc_o,
  input wire mdio_i,
  output reg mdio_o,
  output reg mdio_oe_o,
  output reg mgmt_irq_o
);

  // Bus request decode, one access taken per handshake
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire rd = req & ~wb_we_i;
  wire wr = req & wb_we_i;
  wire [3:0] idx = wb_adr_i[5:2];
  wire lo_ln = wb_sel_i[0];
  wire hi_ln = wb_sel_i[1];

  reg mode16;
  reg [7:0] rx_fifo_overflow_count;
  reg [7:0] tx_attempt_count;
  reg [31:0] tx_byte_total;
  reg txb_frz;
  reg txb_miss;
  reg [BYTE_CNT_W-1:0] last_bytes;
  wire [111:0] cnt_flat;

  // Qualified MAC events; broadcast takes precedence over multicast
  wire rx_ok = rx_frame_end_i & rx_frame_good_i; // R12
  wire tx_ok = tx_frame_end_i & ~tx_retry_indicator_i;
  wire rx_m = rx_ok & rx_dest_mcast_i & ~rx_dest_bcast_i; // R9
  wire rx_b = rx_ok & rx_dest_bcast_i; // R10
  wire rx_u = rx_ok & ~rx_dest_mcast_i & ~rx_dest_bcast_i; // R11
  wire tx_m = tx_ok & tx_dest_mcast_i & ~tx_dest_bcast_i; // R16
  wire tx_b = tx_ok & tx_dest_bcast_i; // R17
  wire tx_u = tx_ok & ~tx_dest_mcast_i & ~tx_dest_bcast_i; // R18
  wire [6:0] ev16 = {tx_u, tx_b, tx_m, rx_u, rx_b, rx_m, tx_defer_i};

  // Control register: host width mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode16 <= 1'b0;
    end else if (wr && idx == `MSP_IDX_CTRL && lo_ln) begin
      mode16 <= wb_dat_i[`MSP_CTRL_MODE16_BIT];
    end
  end

  // Overflow counter; its freeze lasts exactly the single read edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_fifo_overflow_count <= 8'h00;
    end else if (rd && idx == `MSP_IDX_OVF_ATT && lo_ln) begin // R3 R25
      rx_fifo_overflow_count <= rx_fifo_overflow_i ? `MSP_PRESET8 : 8'h00; // R2
    end else if (rx_fifo_overflow_i && rx_fifo_overflow_count != `MSP_SAT8) begin
      rx_fifo_overflow_count <= rx_fifo_overflow_count + 8'h01; // R1
    end
  end

  // Attempt register is plain capture, reads have no side effect
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_attempt_count <= 8'h00;
    end else if (tx_attempt_done_i) begin
      tx_attempt_count <= tx_attempt_count_i; // R4
    end
  end

  // Seven 16-bit saturating counters with freeze and missed-event preset
  genvar k;
  generate
    for (k = 0; k < 7; k = k + 1) begin : g_cnt
      localparam [27:0] IDX_TBL = `MSP_CNT16_IDX;
      localparam [3:0] IDX = IDX_TBL[4*k+3:4*k];
      localparam [15:0] SAT = (k == 5) ? TX_BCAST_SAT : `MSP_SAT16;
      reg [15:0] cnt;
      reg frz;
      reg miss;
      wire hit = rd && idx == IDX;
      wire done_rd = hit & lo_ln;
      wire frz_rd = hit & hi_ln & ~lo_ln & ~mode16;
      always @(posedge clk_i) begin
        if (rst_i) begin
          cnt <= 16'h0000;
          frz <= 1'b0;
          miss <= 1'b0;
        end else if (done_rd) begin
          cnt <= (miss | ev16[k]) ? `MSP_PRESET16 : 16'h0000; // R7 R8 R19
          frz <= 1'b0; // R27
          miss <= 1'b0;
        end else if (frz_rd) begin
          frz <= 1'b1; // R7
          if (ev16[k]) begin
            miss <= 1'b1;
          end
        end else if (ev16[k]) begin
          if (frz) begin
            miss <= 1'b1;
          end else if (cnt != SAT) begin
            cnt <= cnt + 16'h0001; // R6 R9 R10 R11 R16 R17 R18
          end
        end
      end
      assign cnt_flat[16*k+15:16*k] = cnt;
    end
  endgenerate

  // Transmit byte total: wraps, frozen from high-word read to low-word read
  wire txb_done = rd && idx == `MSP_IDX_TXB_LO && lo_ln;
  wire txb_frz_rd = rd && idx == `MSP_IDX_TXB_HI;
  wire [31:0] bytes_ext = {{(32-BYTE_CNT_W){1'b0}}, tx_byte_count_i};
  wire [31:0] last_ext = {{(32-BYTE_CNT_W){1'b0}}, last_bytes};

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_byte_total <= 32'h0000_0000;
      txb_frz <= 1'b0;
      txb_miss <= 1'b0;
      last_bytes <= {BYTE_CNT_W{1'b0}};
    end else begin
      if (tx_ok) begin
        last_bytes <= tx_byte_count_i;
      end
      if (txb_done) begin // R15
        tx_byte_total <= tx_ok ? bytes_ext : (txb_miss ? last_ext : 32'h0000_0000); // R14
        txb_frz <= 1'b0; // R27
        txb_miss <= 1'b0;
      end else if (txb_frz_rd) begin
        txb_frz <= 1'b1;
        if (tx_ok) begin
          txb_miss <= 1'b1;
        end
      end else if (tx_ok) begin
        if (txb_frz) begin
          txb_miss <= 1'b1;
        end else begin
          tx_byte_total <= tx_byte_total + bytes_ext; // R13
        end
      end
    end
  end

  // PHY management command, data and serial engine
  reg [4:0] phy_addr;
  reg [2:0] mdc_div;
  reg [4:0] reg_addr;
  reg op_rd;
  reg irq_en;
  reg mgmt_done;
  reg busy;
  reg [15:0] mgmt_data;
  reg [2:0] div_cnt;
  reg [6:0] bit_cnt;
  reg [63:0] shifter;
  wire cmd_wr = wr && idx == `MSP_IDX_MGMT_CMD && !busy;
  wire data_wr = wr && idx == `MSP_IDX_MGMT_DATA && !busy;
  wire start = cmd_wr & hi_ln;
  wire next_op_rd = wb_dat_i[`MSP_CMD_OP_RD_BIT];
  wire [4:0] next_reg = wb_dat_i[`MSP_CMD_REG_LSB+4:`MSP_CMD_REG_LSB];
  wire [4:0] next_phy = lo_ln ? wb_dat_i[`MSP_CMD_PHY_LSB+4:`MSP_CMD_PHY_LSB] : phy_addr;
  wire tick = busy && div_cnt == mdc_div; // R22
  wire [63:0] frame = {`MSP_MF_PREAMBLE, `MSP_MF_START,
    next_op_rd ? `MSP_MF_OP_RD : `MSP_MF_OP_WR, next_phy, next_reg,
    `MSP_MF_TA_WR, mgmt_data}; // R26

  always @(posedge clk_i) begin
    if (rst_i) begin
      phy_addr <= 5'h00;
      mdc_div <= `MSP_DIV_RESET; // R23
      reg_addr <= 5'h00;
      op_rd <= 1'b0;
      irq_en <= 1'b0;
    end else if (cmd_wr) begin
      if (lo_ln) begin
        phy_addr <= wb_dat_i[`MSP_CMD_PHY_LSB+4:`MSP_CMD_PHY_LSB];
        mdc_div <= wb_dat_i[`MSP_CMD_DIV_LSB+2:`MSP_CMD_DIV_LSB];
      end
      if (hi_ln) begin
        reg_addr <= next_reg;
        op_rd <= next_op_rd;
        irq_en <= wb_dat_i[`MSP_CMD_IE_BIT];
      end
    end
  end

  // Data changes while MDC falls and is sampled as it rises
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      mgmt_done <= 1'b0;
      mgmt_data <= 16'h0000;
      div_cnt <= 3'h0;
      bit_cnt <= 7'h00;
      shifter <= 64'h0;
      mdc_o <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (start) begin // R20
      busy <= 1'b1;
      mgmt_done <= 1'b0;
      div_cnt <= 3'h0;
      shifter <= {frame[62:0], 1'b0};
      mdio_o <= frame[63];
      mdio_oe_o <= 1'b1;
      bit_cnt <= 7'h01;
      mdc_o <= 1'b0;
    end else begin
      if (data_wr && lo_ln) begin
        mgmt_data[7:0] <= wb_dat_i[7:0];
      end
      if (data_wr && hi_ln) begin
        mgmt_data[15:8] <= wb_dat_i[15:8];
      end
      if (busy) begin
        div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
      end
      if (tick && !mdc_o) begin
        mdc_o <= 1'b1;
        if (op_rd && bit_cnt >= `MSP_MF_DATA_SAMPLE) begin
          mgmt_data <= {mgmt_data[14:0], mdio_i}; // R24
        end
      end else if (tick && mdc_o) begin
        mdc_o <= 1'b0;
        if (bit_cnt == `MSP_MF_BITS) begin
          busy <= 1'b0;
          mgmt_done <= 1'b1; // R21
          mdio_oe_o <= 1'b0;
          mdio_o <= 1'b0;
        end else begin
          mdio_o <= shifter[63]; // R24
          shifter <= {shifter[62:0], 1'b0};
          mdio_oe_o <= ~(op_rd && bit_cnt >= `MSP_MF_TA_FIRST);
          bit_cnt <= bit_cnt + 7'h01;
        end
      end
    end
  end

  // Completion interrupt is a level held while done and enabled
  always @(posedge clk_i) begin
    if (rst_i) begin
      mgmt_irq_o <= 1'b0;
    end else if (start) begin
      // Done clears at start, so the level must not linger one clock into the new frame
      mgmt_irq_o <= 1'b0; // R21
    end else begin
      mgmt_irq_o <= mgmt_done & irq_en; // R21
    end
  end

  // Read data mux, sampled at the edge the request is taken
  reg [31:0] next_dat;
  always @* begin
    next_dat = 32'h0000_0000;
    case (idx)
      `MSP_IDX_CTRL: next_dat[`MSP_CTRL_MODE16_BIT] = mode16;
      `MSP_IDX_OVF_ATT: next_dat[15:0] = {tx_attempt_count, rx_fifo_overflow_count}; // R3
      `MSP_IDX_DEFER: next_dat[15:0] = cnt_flat[15:0];
      `MSP_IDX_RX_MCAST: next_dat[15:0] = cnt_flat[31:16];
      `MSP_IDX_RX_BCAST: next_dat[15:0] = cnt_flat[47:32];
      `MSP_IDX_RX_UCAST: next_dat[15:0] = cnt_flat[63:48];
      `MSP_IDX_TXB_LO: next_dat[15:0] = tx_byte_total[15:0];
      `MSP_IDX_TXB_HI: next_dat[15:0] = tx_byte_total[31:16];
      `MSP_IDX_TX_MCAST: next_dat[15:0] = cnt_flat[79:64];
      `MSP_IDX_TX_BCAST: next_dat[15:0] = cnt_flat[95:80];
      `MSP_IDX_TX_UCAST: next_dat[15:0] = cnt_flat[111:96];
      `MSP_IDX_MGMT_CMD: next_dat[15:0] = {mgmt_done, irq_en, op_rd, reg_addr, mdc_div, phy_addr};
      `MSP_IDX_MGMT_DATA: next_dat[15:0] = mgmt_data;
      default: next_dat = 32'h0000_0000;
    endcase
  end

  // Unmapped addresses are acknowledged, read zero and ignore writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= next_dat;
      end
    end
  end

endmodule // msp_stats_mgmt

// ### verif/msp_stats_mgmt_assertions.sv
// Checker for the statistics and management block.
// Sees only top ports; the master never writes the command while busy.
`timescale 1ns/1ps
`include "msp_defines.vh"
module msp_stats_mgmt_assertions (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire mdc_o,
  input wire mdio_o,
  input wire mdio_oe_o,
  input wire mgmt_irq_o
);
  reg [2:0] div;
  reg [3:0] hcnt;
  // Shadow of the divider, so the half period can be checked exactly
  always @(posedge clk_i) begin
    hcnt <= mdc_o ? hcnt + 4'h1 : 4'h0;
    if (rst_i)
      div <= `MSP_DIV_RESET;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i[5:2] == `MSP_IDX_MGMT_CMD)
      div <= wb_dat_i[7:5];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_pre;
    mdio_o [*8];
  endsequence
  a_ack_taken: assert property (s_take |=> s_pulse)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !mdc_o && !mdio_oe_o && !mgmt_irq_o)
    else $error("outputs active after reset");
  a_mdc_half: assert property ($fell(mdc_o) |-> hcnt == {1'b0, div} + 4'h1)
    else $error("mdc high time wrong");
  a_frame_start: assert property ($rose(mdio_oe_o) |-> !mdc_o ##0 s_pre)
    else $error("frame does not open with preamble");
  a_mdio_on_fall: assert property (mdio_oe_o && $past(mdio_oe_o) && $changed(mdio_o) |-> $fell(mdc_o))
    else $error("data changed away from mdc fall");
  a_irq_idle: assert property (mgmt_irq_o |-> !mdio_oe_o && !mdc_o)
    else $error("irq while link busy");
  a_oe_release: assert property ($fell(mdio_oe_o) |-> !mdc_o)
    else $error("release while mdc high");
endmodule // msp_stats_mgmt_assertions
bind msp_stats_mgmt msp_stats_mgmt_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .mdc_o, .mdio_o, .mdio_oe_o, .mgmt_irq_o);

// ### verif/msp_phy_model.sv
// Far-end PHY management port model.
// Assumes a pulled-up data wire; answers reads from rd_data_i.
`timescale 1ns/1ps
module msp_phy_model (
  input wire mdc_i,
  input wire mdio_i,
  input wire [15:0] rd_data_i,
  output reg drv_o = 1'b0,
  output reg dat_o = 1'b1,
  output reg [63:0] frame_o = 64'h0
);
  reg [6:0] n = 7'h00;
  reg rd_op = 1'b0;
  reg [15:0] sh = 16'h0;
  // Drives just after the rising edge, like a real port
  always @(posedge mdc_i) begin
    frame_o <= {frame_o[62:0], mdio_i};
    n <= (n == 7'd63) ? 7'd0 : n + 7'd1;
    if (n == 7'd35)
      rd_op <= {frame_o[0], mdio_i} == 2'b10;
    drv_o <= rd_op && n >= 7'd46 && n < 7'd63;
    if (n == 7'd46) begin
      sh <= rd_data_i;
      dat_o <= 1'b0;
    end else begin
      dat_o <= sh[15];
      sh <= {sh[14:0], 1'b0};
    end
  end
endmodule // msp_phy_model

// ### verif/msp_stats_mgmt_bench.sv
// Testbench for the statistics and management block.
// Drives Wishbone, MAC event pulses and a PHY model.
`timescale 1ns/1ps
module msp_stats_mgmt_bench;
  localparam [11:0] RX_KINDS = 12'hde2;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [5:0] adr = 6'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] wdat = 32'h0;
  reg [4:0] ev = 5'h00;
  reg [2:0] rq = 3'h0;
  reg [2:0] tq = 3'h0;
  reg [15:0] nb = 16'h0;
  reg [7:0] att = 8'h00;
  reg [15:0] prd = 16'h0;
  reg [15:0] got;
  integer n_fail = 0;
  integer checked = 0;
  integer k;
  wire [31:0] rdat;
  wire ack, mdc, mdo, moe, irq, pdrv, pdat;
  wire [63:0] frame;
  wire mdio = moe ? mdo : (pdrv ? pdat : 1'b1);
  initial forever #4 clk_i = ~clk_i;
  msp_stats_mgmt uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_fifo_overflow_i(ev[0]), .tx_attempt_done_i(ev[1]), .tx_attempt_count_i(att), .tx_defer_i(ev[2]),
    .rx_frame_end_i(ev[3]), .rx_frame_good_i(rq[2]), .rx_dest_mcast_i(rq[1]), .rx_dest_bcast_i(rq[0]),
    .tx_frame_end_i(ev[4]), .tx_retry_indicator_i(tq[2]), .tx_dest_mcast_i(tq[1]), .tx_dest_bcast_i(tq[0]),
    .tx_byte_count_i(nb), .mdc_o(mdc), .mdio_i(mdio), .mdio_o(mdo), .mdio_oe_o(moe), .mgmt_irq_o(irq));
  msp_phy_model phy (.mdc_i(mdc), .mdio_i(mdio), .rd_data_i(prd), .drv_o(pdrv), .dat_o(pdat), .frame_o(frame));
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task hang;
    begin
      n_fail = n_fail + 1;
      $display("BAD %0t timeout", $time);
      tally_and_finish;
    end
  endtask
  task chk(input [63:0] e, input [63:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("BAD %0t expected %h got %h", $time, e, g);
      end
    end
  endtask
  // Event mask pe lands on the edge that takes the request
  task acc(input w, input [3:0] idx, input [3:0] s, input [15:0] d, input [4:0] pe);
    integer i;
    begin
      @(posedge clk_i);
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= s;
      wdat <= {16'h0000, d};
      ev <= pe;
      @(posedge clk_i);
      ev <= 5'h00;
      for (i = 0; ack !== 1'b1; i = i + 1) begin
        if (i > 50)
          hang;
        @(posedge clk_i);
      end
      got = rdat[15:0];
      stb <= 1'b0;
    end
  endtask
  task rd(input [3:0] idx, input [3:0] s, input [4:0] pe, input [15:0] e);
    begin
      acc(1'b0, idx, s, 16'h0, pe);
      chk({48'h0, e}, {32'h0, rdat});
    end
  endtask
  task pulse(input [4:0] m, input integer n);
    repeat (n) begin
      @(posedge clk_i);
      ev <= m;
      @(posedge clk_i);
      ev <= 5'h00;
    end
  endtask
  task txf(input [2:0] q, input [15:0] b);
    begin
      tq <= q;
      nb <= b;
      pulse(5'h10, 1);
    end
  endtask
  task waitirq(input v);
    integer i;
    for (i = 0; irq !== v; i = i + 1) begin
      if (i > 3000)
        hang;
      @(posedge clk_i);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'hb, 4'h3, 5'h00, 16'h00e0);
    acc(1'b1, 4'hd, 4'h3, 16'hffff, 5'h00);
    rd(4'hd, 4'h3, 5'h00, 16'h0000);
    $display("test reset done");
    pulse(5'h01, 300);
    rd(4'h1, 4'h1, 5'h00, 16'h00ff);
    att <= 8'h05;
    pulse(5'h02, 1);
    rd(4'h1, 4'h3, 5'h01, 16'h0500);
    rd(4'h1, 4'h1, 5'h00, 16'h0501);
    $display("test overflow done");
    pulse(5'h04, 3);
    rd(4'h2, 4'h2, 5'h00, 16'h0003);
    pulse(5'h04, 2);
    rd(4'h2, 4'h1, 5'h00, 16'h0003);
    rd(4'h2, 4'h3, 5'h00, 16'h0001);
    acc(1'b1, 4'h0, 4'h1, 16'h0001, 5'h00);
    pulse(5'h01, 2);
    rd(4'h1, 4'h2, 5'h00, 16'h0502);
    rd(4'h1, 4'h1, 5'h00, 16'h0502);
    rd(4'h1, 4'h1, 5'h00, 16'h0500);
    pulse(5'h04, 4);
    rd(4'h2, 4'h2, 5'h00, 16'h0004);
    rd(4'h2, 4'h3, 5'h04, 16'h0004);
    rd(4'h2, 4'h3, 5'h00, 16'h0001);
    $display("test deferral done");
    for (k = 0; k < 4; k = k + 1) begin
      rq <= RX_KINDS[11 - 3 * k -: 3];
      pulse(5'h08, 1);
    end
    rd(4'h3, 4'h3, 5'h00, 16'h0001);
    rd(4'h4, 4'h3, 5'h00, 16'h0001);
    rd(4'h5, 4'h3, 5'h00, 16'h0001);
    rd(4'h3, 4'h3, 5'h00, 16'h0000);
    $display("test rx done");
    txf(3'b000, 16'd100);
    txf(3'b110, 16'd60);
    txf(3'b010, 16'd24);
    txf(3'b011, 16'd40);
    rd(4'h7, 4'h3, 5'h00, 16'h0000);
    txf(3'b000, 16'd20);
    rd(4'h6, 4'h3, 5'h00, 16'h00a4);
    rd(4'h6, 4'h3, 5'h00, 16'h0014);
    rd(4'h8, 4'h3, 5'h00, 16'h0001);
    rd(4'h9, 4'h3, 5'h00, 16'h0001);
    rd(4'ha, 4'h3, 5'h00, 16'h0002);
    $display("test tx done");
    acc(1'b1, 4'hc, 4'h3, 16'ha5c3, 5'h00);
    acc(1'b1, 4'hb, 4'h3, 16'h4123, 5'h00);
    waitirq(1'b1);
    chk({32'hffff_ffff, 2'b01, 2'b01, 5'h03, 5'h01, 2'b10, 16'ha5c3}, frame);
    rd(4'hb, 4'h3, 5'h00, 16'hc123);
    prd <= 16'h3c5a;
    acc(1'b1, 4'hb, 4'h3, 16'h6102, 5'h00);
    waitirq(1'b0);
    waitirq(1'b1);
    rd(4'hc, 4'h3, 5'h00, 16'h3c5a);
    $display("test mgmt done");
    tally_and_finish;
  end
endmodule // msp_stats_mgmt_bench
